/* File: design/pmr_pkg.sv */
// Constants, register layouts and carrier types of the management register bank.
package pmr_pkg;

   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam int unsigned SRST_TIME_NS = 1000;
   localparam int unsigned SRST_CYCLES = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SYNC_CYCLES = 2;
   localparam int unsigned TMR_W = 8;
   localparam logic [TMR_W-1:0] SRST_LAST = TMR_W'(SRST_CYCLES - 1);
   localparam logic [TMR_W-1:0] LOAD_LAST = TMR_W'(SYNC_CYCLES);
   localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;

   localparam int unsigned CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

   localparam logic [4:0] ADDR_BMC = 5'h00;
   localparam logic [4:0] ADDR_PCE = 5'h19;
   localparam logic [4:0] ADDR_TBS = 5'h1a;
   localparam logic [4:0] ADDR_TPB = 5'h1b;
   localparam logic [4:0] ADDR_RSA = 5'h1c;
   localparam logic [4:0] ADDR_EDC = 5'h1d;

   localparam logic FIXED_BIT = 1'b1;

   localparam int unsigned LATCH_N = 2;
   localparam int unsigned LAT_BIST = 0;
   localparam int unsigned LAT_POL = 1;
   localparam logic [LATCH_N-1:0] LATCH_ACTIVE = 2'h2;

   typedef logic [15:0] pmr_word_t;

   typedef struct packed {
      logic reset;
      logic loopback;
      logic [13:0] rsvd;
   } pmr_bmc_t;

   typedef struct packed {
      logic mdix_en;
      logic force_mdix;
      logic pause_rx;
      logic pause_tx;
      logic bist_fe;
      logic psr_15;
      logic bist_status;
      logic bist_start;
      logic bp_stretch;
      logic [1:0] led_cfg;
      logic [4:0] phy_addr;
   } pmr_pce_t;

   typedef struct packed {
      logic [3:0] rsvd_hi;
      logic [2:0] squelch;
      logic loop10_dis;
      logic lp_dis;
      logic force_link_10;
      logic fixed_one;
      logic polarity;
      logic [1:0] rsvd_lo;
      logic heartbeat_dis;
      logic jabber_dis;
   } pmr_tbs_t;

   typedef struct packed {
      logic [7:0] bist_err_cnt;
      logic [1:0] rsvd_hi;
      logic bist_cont;
      logic pat_en_10;
      logic rsvd_lo;
      logic pat_gap_10;
      logic [1:0] pat_sel;
   } pmr_tpb_t;

   typedef struct packed {
      logic ed_en;
      logic auto_up;
      logic auto_down;
      logic ed_man;
      logic burst_dis;
      logic pwr_state;
      logic err_met;
      logic data_met;
      logic [3:0] err_cnt;
      logic [3:0] data_cnt;
   } pmr_edc_t;

   typedef struct packed {
      pmr_pce_t pce;
      pmr_tbs_t tbs;
      pmr_tpb_t tpb;
      pmr_edc_t edc;
   } pmr_cfg_t;

   localparam pmr_cfg_t CFG_RST = '{
      pce: '0,
      tbs: '{rsvd_hi: 4'h0, squelch: 3'h4, fixed_one: FIXED_BIT, default: 1'b0},
      tpb: '0,
      edc: '{err_cnt: 4'h1, data_cnt: 4'h1, default: 1'b0}
   };

   typedef struct packed {
      logic [4:0] phy_addr;
      logic [1:0] led_cfg;
      logic mdix_en;
   } pmr_strap_t;

   typedef struct packed {
      logic pause_rx;
      logic pause_tx;
      logic bist_pass;
      logic bist_done;
      logic bist_err;
      logic polarity_rev;
      logic ed_pwr_state;
      logic ed_err_met;
      logic ed_data_met;
   } pmr_stat_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] addr;
      pmr_word_t wdata;
   } pmr_req_t;

   typedef struct packed {
      logic dv;
      logic [3:0] d;
   } pmr_mii_t;

   typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_SRST} pmr_state_t;

   typedef enum logic [2:0] {SEL_NONE, SEL_BMC, SEL_PCE, SEL_TBS, SEL_TPB, SEL_EDC} pmr_sel_t;

endpackage

/* File: design/pmr_latch_bit.sv */
`timescale 1ns/10ps
// Status bit that latches its active level until a management read.
module pmr_latch_bit #(
   parameter logic ACTIVE = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_clr,
   input wire logic i_live,
   input wire logic i_rd,
   output logic o_val
);

   logic held_r;
   logic held_nxt;

   always_comb begin
      held_nxt = held_r;
      if (i_clr) begin
         held_nxt = 1'b0;
      end else if (i_live == ACTIVE) begin
         held_nxt = 1'b1;
      end else if (i_rd) begin
         held_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         held_r <= 1'b0;
      end else if (i_ce) begin
         held_r <= held_nxt;
      end
   end

   assign o_val = held_r ? ACTIVE : i_live;

endmodule

/* File: design/pmr_cor_count.sv */
`timescale 1ns/10ps
// Saturating event counter that clears when it is read.
module pmr_cor_count (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_clr,
   input wire logic i_inc,
   input wire logic i_rd,
   output logic [pmr_pkg::CNT_W-1:0] o_cnt
);

   logic [pmr_pkg::CNT_W-1:0] cnt_r;
   logic [pmr_pkg::CNT_W-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (i_clr) begin
         cnt_nxt = '0;
      end else if (i_inc && i_rd) begin
         cnt_nxt = pmr_pkg::CNT_ONE;
      end else if (i_inc && cnt_r != pmr_pkg::CNT_MAX) begin
         cnt_nxt = cnt_r + pmr_pkg::CNT_ONE;
      end else if (i_rd) begin
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cnt_r <= '0;
      end else if (i_ce) begin
         cnt_r <= cnt_nxt;
      end
   end

   assign o_cnt = cnt_r;

endmodule

/* File: design/pmr_regbank.sv */
`timescale 1ns/10ps
// Management register bank with software reset, loopback and extended registers.
module pmr_regbank (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire pmr_pkg::pmr_req_t i_req,
   input wire pmr_pkg::pmr_strap_t i_strap,
   input wire pmr_pkg::pmr_stat_t i_stat,
   input wire pmr_pkg::pmr_mii_t i_mii_tx,
   input wire pmr_pkg::pmr_mii_t i_line_rx,
   output pmr_pkg::pmr_word_t o_rdata,
   output logic o_rvalid,
   output logic o_sw_reset,
   output logic o_loopback,
   output pmr_pkg::pmr_cfg_t o_cfg,
   output pmr_pkg::pmr_mii_t o_mii_rx,
   output pmr_pkg::pmr_mii_t o_line_tx
);

   function automatic pmr_pkg::pmr_sel_t decode(input logic [4:0] addr);
      pmr_pkg::pmr_sel_t sel;
      sel = pmr_pkg::SEL_NONE;
      if (addr == pmr_pkg::ADDR_BMC) begin
         sel = pmr_pkg::SEL_BMC;
      end else if (addr == pmr_pkg::ADDR_PCE) begin
         sel = pmr_pkg::SEL_PCE;
      end else if (addr == pmr_pkg::ADDR_TBS) begin
         sel = pmr_pkg::SEL_TBS;
      end else if (addr == pmr_pkg::ADDR_TPB) begin
         sel = pmr_pkg::SEL_TPB;
      end else if (addr == pmr_pkg::ADDR_EDC) begin
         sel = pmr_pkg::SEL_EDC;
      end
      return sel;
   endfunction

   // Strap pins pass two flip-flops before use.
   pmr_pkg::pmr_strap_t strap_m_r;
   pmr_pkg::pmr_strap_t strap_s_r;

   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         strap_m_r <= i_strap;
         strap_s_r <= strap_m_r;
      end
   end

   pmr_pkg::pmr_state_t st_r;
   pmr_pkg::pmr_state_t st_nxt;
   logic [pmr_pkg::TMR_W-1:0] tmr_r;
   logic [pmr_pkg::TMR_W-1:0] tmr_nxt;
   logic busy_r;
   logic busy_nxt;
   logic loop_r;
   logic loop_nxt;
   pmr_pkg::pmr_cfg_t cfg_r;
   pmr_pkg::pmr_cfg_t cfg_nxt;

   pmr_pkg::pmr_sel_t wr_sel;
   pmr_pkg::pmr_sel_t rd_sel;
   logic bank_clr;
   logic wr_ok;
   pmr_pkg::pmr_bmc_t bmc_w;
   pmr_pkg::pmr_pce_t pce_w;
   pmr_pkg::pmr_tbs_t tbs_w;
   pmr_pkg::pmr_tpb_t tpb_w;
   pmr_pkg::pmr_edc_t edc_w;

   assign wr_sel = decode(i_req.addr);
   assign rd_sel = decode(i_req.addr);
   assign bank_clr = (st_r != pmr_pkg::ST_RUN);
   assign wr_ok = i_req.wr && (st_r == pmr_pkg::ST_RUN);

   always_comb begin
      bmc_w = i_req.wdata;
      pce_w = i_req.wdata;
      pce_w.pause_rx = 1'b0;
      pce_w.pause_tx = 1'b0;
      pce_w.bist_status = 1'b0;
      pce_w.phy_addr = cfg_r.pce.phy_addr;
      tbs_w = i_req.wdata;
      tbs_w.rsvd_hi = '0;
      tbs_w.rsvd_lo = '0;
      tbs_w.fixed_one = pmr_pkg::FIXED_BIT;
      tbs_w.polarity = 1'b0;
      tpb_w = i_req.wdata;
      tpb_w.bist_err_cnt = '0;
      tpb_w.rsvd_hi = '0;
      tpb_w.rsvd_lo = 1'b0;
      edc_w = i_req.wdata;
      edc_w.pwr_state = 1'b0;
      edc_w.err_met = 1'b0;
      edc_w.data_met = 1'b0;
   end

   always_comb begin
      st_nxt = st_r;
      tmr_nxt = tmr_r;
      loop_nxt = loop_r;
      cfg_nxt = cfg_r;
      case (st_r)
         pmr_pkg::ST_LOAD: begin
            cfg_nxt = pmr_pkg::CFG_RST;
            cfg_nxt.pce.phy_addr = strap_s_r.phy_addr;
            cfg_nxt.pce.led_cfg = strap_s_r.led_cfg;
            cfg_nxt.pce.mdix_en = strap_s_r.mdix_en;
            loop_nxt = 1'b0;
            tmr_nxt = tmr_r + pmr_pkg::TMR_ONE;
            if (tmr_r == pmr_pkg::LOAD_LAST) begin
               st_nxt = pmr_pkg::ST_RUN;
               tmr_nxt = '0;
            end
         end
         pmr_pkg::ST_SRST: begin
            tmr_nxt = tmr_r + pmr_pkg::TMR_ONE;
            if (tmr_r == pmr_pkg::SRST_LAST) begin
               st_nxt = pmr_pkg::ST_LOAD;
               tmr_nxt = '0;
            end
         end
         default: begin
            if (i_stat.bist_done) begin
               cfg_nxt.pce.bist_start = 1'b0;
            end
            if (wr_ok) begin
               if (wr_sel == pmr_pkg::SEL_BMC) begin
                  loop_nxt = bmc_w.loopback;
                  if (bmc_w.reset) begin
                     st_nxt = pmr_pkg::ST_SRST;
                     tmr_nxt = '0;
                     loop_nxt = 1'b0;
                  end
               end else if (wr_sel == pmr_pkg::SEL_PCE) begin
                  cfg_nxt.pce = pce_w;
                  if (i_stat.bist_done && !pce_w.bist_start) begin
                     cfg_nxt.pce.bist_start = 1'b0;
                  end
               end else if (wr_sel == pmr_pkg::SEL_TBS) begin
                  cfg_nxt.tbs = tbs_w;
               end else if (wr_sel == pmr_pkg::SEL_TPB) begin
                  cfg_nxt.tpb = tpb_w;
               end else if (wr_sel == pmr_pkg::SEL_EDC) begin
                  cfg_nxt.edc = edc_w;
               end
            end
         end
      endcase
      busy_nxt = (st_nxt != pmr_pkg::ST_RUN);
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         st_r <= pmr_pkg::ST_LOAD;
         tmr_r <= '0;
         busy_r <= 1'b1;
         loop_r <= 1'b0;
         cfg_r <= pmr_pkg::CFG_RST;
      end else if (i_ce) begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         busy_r <= busy_nxt;
         loop_r <= loop_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   // Latched status bits and the clear-on-read error counter.
   logic [pmr_pkg::LATCH_N-1:0] lat_live;
   logic [pmr_pkg::LATCH_N-1:0] lat_rd;
   logic [pmr_pkg::LATCH_N-1:0] lat_val;
   logic rd_run;
   logic [pmr_pkg::CNT_W-1:0] err_cnt;

   assign rd_run = i_req.rd && (st_r == pmr_pkg::ST_RUN);
   assign lat_live[pmr_pkg::LAT_BIST] = i_stat.bist_pass;
   assign lat_live[pmr_pkg::LAT_POL] = i_stat.polarity_rev;
   assign lat_rd[pmr_pkg::LAT_BIST] = rd_run && (rd_sel == pmr_pkg::SEL_PCE);
   assign lat_rd[pmr_pkg::LAT_POL] = rd_run && (rd_sel == pmr_pkg::SEL_TBS);

   genvar gi;
   generate
      for (gi = 0; gi < pmr_pkg::LATCH_N; gi++) begin : g_lat
         pmr_latch_bit #(
            .ACTIVE(pmr_pkg::LATCH_ACTIVE[gi])
         ) u_lat (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_ce(i_ce),
            .i_clr(bank_clr),
            .i_live(lat_live[gi]),
            .i_rd(lat_rd[gi]),
            .o_val(lat_val[gi])
         );
      end
   endgenerate

   pmr_cor_count u_err_cnt (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .i_clr(bank_clr),
      .i_inc(i_stat.bist_err),
      .i_rd(rd_run && (rd_sel == pmr_pkg::SEL_TPB)),
      .o_cnt(err_cnt)
   );

   // Read path returns the value seen before any clear-on-read side effect.
   pmr_pkg::pmr_word_t rdata_r;
   pmr_pkg::pmr_word_t rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   pmr_pkg::pmr_bmc_t bmc_rd;
   pmr_pkg::pmr_pce_t pce_rd;
   pmr_pkg::pmr_tbs_t tbs_rd;
   pmr_pkg::pmr_tpb_t tpb_rd;
   pmr_pkg::pmr_edc_t edc_rd;

   always_comb begin
      bmc_rd = '0;
      bmc_rd.reset = busy_r;
      bmc_rd.loopback = loop_r;
      pce_rd = cfg_r.pce;
      pce_rd.pause_rx = i_stat.pause_rx;
      pce_rd.pause_tx = i_stat.pause_tx;
      pce_rd.bist_status = lat_val[pmr_pkg::LAT_BIST];
      tbs_rd = cfg_r.tbs;
      tbs_rd.fixed_one = pmr_pkg::FIXED_BIT;
      tbs_rd.polarity = lat_val[pmr_pkg::LAT_POL];
      tpb_rd = cfg_r.tpb;
      tpb_rd.bist_err_cnt = err_cnt;
      edc_rd = cfg_r.edc;
      edc_rd.pwr_state = i_stat.ed_pwr_state;
      edc_rd.err_met = i_stat.ed_err_met;
      edc_rd.data_met = i_stat.ed_data_met;
      rvalid_nxt = i_req.rd;
      rdata_nxt = rdata_r;
      if (i_req.rd) begin
         if (rd_sel == pmr_pkg::SEL_BMC) begin
            rdata_nxt = bmc_rd;
         end else if (busy_r) begin
            rdata_nxt = '0;
         end else if (rd_sel == pmr_pkg::SEL_PCE) begin
            rdata_nxt = pce_rd;
         end else if (rd_sel == pmr_pkg::SEL_TBS) begin
            rdata_nxt = tbs_rd;
         end else if (rd_sel == pmr_pkg::SEL_TPB) begin
            rdata_nxt = tpb_rd;
         end else if (rd_sel == pmr_pkg::SEL_EDC) begin
            rdata_nxt = edc_rd;
         end else begin
            rdata_nxt = '0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rdata_r <= '0;
         rvalid_r <= 1'b0;
      end else if (i_ce) begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // Media-independent data path with loopback steering.
   pmr_pkg::pmr_mii_t rx_r;
   pmr_pkg::pmr_mii_t rx_nxt;
   pmr_pkg::pmr_mii_t tx_r;
   pmr_pkg::pmr_mii_t tx_nxt;

   always_comb begin
      if (loop_r) begin
         rx_nxt = i_mii_tx;
         tx_nxt = '0;
      end else begin
         rx_nxt = i_line_rx;
         tx_nxt = i_mii_tx;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rx_r <= '0;
         tx_r <= '0;
      end else if (i_ce) begin
         rx_r <= rx_nxt;
         tx_r <= tx_nxt;
      end
   end

   assign o_rdata = rdata_r;
   assign o_rvalid = rvalid_r;
   assign o_sw_reset = busy_r;
   assign o_loopback = loop_r;
   assign o_cfg = cfg_r;
   assign o_mii_rx = rx_r;
   assign o_line_tx = tx_r;

endmodule

/* File: test/pmr_regbank_chk.sv */
// Port checker of the management register bank.
`timescale 1ns/10ps
module pmr_regbank_chk (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire pmr_pkg::pmr_req_t i_req,
   input wire pmr_pkg::pmr_mii_t i_mii_tx,
   input wire pmr_pkg::pmr_mii_t i_line_rx,
   input wire pmr_pkg::pmr_word_t o_rdata,
   input wire logic o_rvalid,
   input wire logic o_sw_reset,
   input wire logic o_loopback,
   input wire pmr_pkg::pmr_mii_t o_mii_rx,
   input wire pmr_pkg::pmr_mii_t o_line_tx
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   logic rd_go;
   logic wr0;
   assign rd_go = i_req.rd && i_ce;
   assign wr0 = i_req.wr && i_ce && !o_sw_reset && i_req.addr == 5'h00;
   sequence s_srst_run;
      o_sw_reset throughout (##52 1'b1);
   endsequence
   sequence s_srst_end;
      !o_sw_reset;
   endsequence
   property p_rvalid;
      $past(i_nrst) && $past(i_ce) |-> o_rvalid == $past(rd_go);
   endproperty
   property p_srst_go;
      wr0 && i_req.wdata[15] |=> o_sw_reset && !o_loopback;
   endproperty
   property p_srst_len;
      $rose(o_sw_reset) |-> s_srst_run ##1 s_srst_end;
   endproperty
   property p_hw_load;
      $rose(i_nrst) |-> o_sw_reset[*3] ##[1:2] s_srst_end;
   endproperty
   property p_busy_rd;
      rd_go && o_sw_reset && i_req.addr == 5'h00 |=> o_rdata[15];
   endproperty
   property p_loop_wr;
      wr0 && !i_req.wdata[15] |=> o_loopback == $past(i_req.wdata[14]);
   endproperty
   property p_loop_rx;
      $past(i_ce) && o_loopback && $past(o_loopback) |->
         o_mii_rx == $past(i_mii_tx) && o_line_tx == 5'h00;
   endproperty
   property p_line_tx;
      $past(i_nrst) && $past(i_ce) && !o_loopback && !$past(o_loopback) |->
         o_line_tx == $past(i_mii_tx);
   endproperty
   property p_line_rx;
      $past(i_nrst) && $past(i_ce) && !o_loopback && !$past(o_loopback) |->
         o_mii_rx == $past(i_line_rx);
   endproperty
   property p_rsvd;
      rd_go && (i_req.addr inside {[5'h01:5'h18], 5'h1c, 5'h1e, 5'h1f}) |=> o_rdata == 16'h0000;
   endproperty
   property p_fixed;
      rd_go && !o_sw_reset && i_req.addr == 5'h1a |=> o_rdata[5];
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer pulse misplaced");
   a_srst_go: assert property (p_srst_go) else $error("software reset did not start");
   a_srst_len: assert property (p_srst_len) else $error("software reset length wrong");
   a_hw_load: assert property (p_hw_load) else $error("strap load length wrong");
   a_busy_rd: assert property (p_busy_rd) else $error("reset bit low while busy");
   a_loop_wr: assert property (p_loop_wr) else $error("loopback bit not stored");
   a_loop_rx: assert property (p_loop_rx) else $error("loopback path wrong");
   a_line_tx: assert property (p_line_tx) else $error("transmit path wrong");
   a_line_rx: assert property (p_line_rx) else $error("receive path wrong");
   a_rsvd: assert property (p_rsvd) else $error("reserved address read not zero");
   a_fixed: assert property (p_fixed) else $error("fixed bit not one");
endmodule
bind pmr_regbank pmr_regbank_chk u_pmr_regbank_chk (.i_clk, .i_nrst, .i_ce, .i_req,
   .i_mii_tx, .i_line_rx, .o_rdata, .o_rvalid, .o_sw_reset, .o_loopback, .o_mii_rx,
   .o_line_tx);

/* File: test/pmr_mgmt_model.sv */
// Management controller model that issues register accesses to the bank.
`timescale 1ns/10ps
module pmr_mgmt_model (
   input wire logic i_clk,
   input wire pmr_pkg::pmr_word_t i_rdata,
   output pmr_pkg::pmr_req_t o_req
);
   initial begin
      o_req = '0;
   end
   task automatic wr(input logic [4:0] a, input pmr_pkg::pmr_word_t v);
      @(posedge i_clk);
      o_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
      @(posedge i_clk);
      o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
   endtask
   task automatic rd(input logic [4:0] a, output pmr_pkg::pmr_word_t v);
      @(posedge i_clk);
      o_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
      @(posedge i_clk);
      o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hffff};
      @(posedge i_clk);
      v = i_rdata;
   endtask
   task automatic wait_ready(output int polls);
      pmr_pkg::pmr_word_t v;
      polls = 0;
      v = 16'h8000;
      while (v[15] === 1'b1 && polls < 200) begin
         rd(5'h00, v);
         polls++;
      end
   endtask
endmodule

/* File: test/pmr_regbank_bench.sv */
// Self-checking bench of the management register bank.
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module pmr_regbank_bench;
   logic i_clk, i_nrst, i_ce, rvalid, sw_reset, loopback;
   pmr_pkg::pmr_req_t req;
   pmr_pkg::pmr_strap_t strap, got_s;
   pmr_pkg::pmr_stat_t stat;
   pmr_pkg::pmr_mii_t mii_tx, line_rx, mii_rx, line_tx, prev_tx;
   pmr_pkg::pmr_word_t rdata, d;
   pmr_pkg::pmr_cfg_t cfg;
   localparam pmr_pkg::pmr_stat_t IDLE = '{bist_pass: 1'b1, default: 1'b0};
   logic [4:0] rsv [4] = '{5'h01, 5'h13, 5'h1c, 5'h1f};
   int cnt_n [2];
   int seed = 67909;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int polls;
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   pmr_mgmt_model u_pmr_mgmt_model (.i_clk(i_clk), .i_rdata(rdata), .o_req(req));
   pmr_regbank u_pmr_regbank (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_req(req),
      .i_strap(strap), .i_stat(stat), .i_mii_tx(mii_tx), .i_line_rx(line_rx), .o_rdata(rdata),
      .o_rvalid(rvalid), .o_sw_reset(sw_reset), .o_loopback(loopback), .o_cfg(cfg),
      .o_mii_rx(mii_rx), .o_line_tx(line_tx));
   task automatic results();
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic stat_pulse(input pmr_pkg::pmr_stat_t s);
      @(posedge i_clk);
      stat <= s;
      @(posedge i_clk);
      stat <= IDLE;
   endtask
   always @(posedge i_clk) begin
      mii_tx <= 5'($random(seed));
      line_rx <= 5'($random(seed));
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      i_nrst = 1'b0;
      i_ce = 1'b1;
      strap = 8'($random(seed));
      stat = IDLE;
      mii_tx = 5'h00;
      line_rx = 5'h00;
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      u_pmr_mgmt_model.wait_ready(polls);
      got_s = {cfg.pce.phy_addr, cfg.pce.led_cfg, cfg.pce.mdix_en};
      `CHK(got_s, strap)
      u_pmr_mgmt_model.wr(5'h1a, 16'h0000);
      u_pmr_mgmt_model.rd(5'h1a, d);
      `CHK(d[5], 1'b1)
      u_pmr_mgmt_model.wr(5'h1a, 16'hffff);
      u_pmr_mgmt_model.rd(5'h1a, d);
      `CHK(d[15:12], 4'h0)
      foreach (rsv[i]) begin
         u_pmr_mgmt_model.wr(rsv[i], 16'hffff);
         u_pmr_mgmt_model.rd(rsv[i], d);
         `CHK(d, 16'h0000)
      end
      cnt_n[0] = 3 + ($random(seed) & 15);
      cnt_n[1] = 300;
      foreach (cnt_n[i]) begin
         repeat (cnt_n[i]) stat_pulse('{bist_pass: 1'b1, bist_err: 1'b1, default: 1'b0});
         u_pmr_mgmt_model.rd(5'h1b, d);
         `CHK(d[15:8], 8'((cnt_n[i] > 255) ? 255 : cnt_n[i]))
      end
      u_pmr_mgmt_model.rd(5'h1b, d);
      `CHK(d[15:8], 8'h00)
      u_pmr_mgmt_model.rd(5'h19, d);
      stat_pulse('{default: 1'b0});
      u_pmr_mgmt_model.rd(5'h19, d);
      `CHK(d[9], 1'b0)
      u_pmr_mgmt_model.rd(5'h19, d);
      `CHK(d[9], 1'b1)
      u_pmr_mgmt_model.rd(5'h1a, d);
      stat_pulse('{bist_pass: 1'b1, polarity_rev: 1'b1, default: 1'b0});
      u_pmr_mgmt_model.rd(5'h1a, d);
      `CHK(d[4], 1'b1)
      u_pmr_mgmt_model.rd(5'h1a, d);
      `CHK(d[4], 1'b0)
      u_pmr_mgmt_model.wr(5'h19, 16'h0100);
      @(posedge i_clk);
      `CHK(cfg.pce.bist_start, 1'b1)
      stat_pulse('{bist_pass: 1'b1, bist_done: 1'b1, default: 1'b0});
      u_pmr_mgmt_model.rd(5'h19, d);
      `CHK(d[8], 1'b0)
      u_pmr_mgmt_model.wr(5'h00, 16'h4000);
      @(posedge i_clk);
      `CHK(loopback, 1'b1)
      repeat (20) begin
         prev_tx = mii_tx;
         @(posedge i_clk);
         `CHK(mii_rx, prev_tx)
         `CHK(line_tx, 5'h00)
      end
      @(posedge i_clk);
      i_ce <= 1'b0;
      @(posedge i_clk);
      prev_tx = mii_rx;
      repeat (3) @(posedge i_clk);
      `CHK(mii_rx, prev_tx)
      `CHK(loopback, 1'b1)
      i_ce <= 1'b1;
      strap <= 8'($random(seed));
      repeat (4) @(posedge i_clk);
      u_pmr_mgmt_model.wr(5'h00, 16'h8000);
      @(posedge i_clk);
      `CHK(sw_reset, 1'b1)
      `CHK(loopback, 1'b0)
      u_pmr_mgmt_model.rd(5'h00, d);
      `CHK(d[15], 1'b1)
      u_pmr_mgmt_model.wr(5'h00, 16'h4000);
      u_pmr_mgmt_model.wait_ready(polls);
      `CHK(polls > 8 && polls < 25, 1'b1)
      `CHK(loopback, 1'b0)
      got_s = {cfg.pce.phy_addr, cfg.pce.led_cfg, cfg.pce.mdix_en};
      `CHK(got_s, strap)
      results();
   end
endmodule
